/* File: rspr_pkg.sv */
// Shared constants for the remote speed pot and run output block
package rspr_pkg;
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_SRC = 6'h04;
	localparam logic [5:0] OFS_STD_FREQ = 6'h08;
	localparam logic [5:0] OFS_MAX_FREQ = 6'h0C;
	localparam logic [5:0] OFS_START_FREQ = 6'h10;
	localparam logic [5:0] OFS_FIRST_ACCEL_TIME = 6'h14;
	localparam logic [5:0] OFS_FIRST_DECEL_TIME = 6'h18;
	localparam logic [5:0] OFS_ACC2 = 6'h1C;
	localparam logic [5:0] OFS_DEC2 = 6'h20;
	localparam logic [5:0] OFS_ROUTE = 6'h24;
	localparam logic [5:0] OFS_STATUS = 6'h28;
	localparam logic [5:0] OFS_OUT_FREQ = 6'h2C;
	// Control register fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_JOG_BIT = 1;
	localparam int CTRL_SET2_BIT = 2;
	// Status register fields
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_RAISE_BIT = 1;
	localparam int STAT_LOWER_BIT = 2;
	localparam int STAT_STATE_LSB = 4;
	// Routing register: one 8-bit function code per terminal
	localparam int ROUTE_FIELD_W = 8;
	localparam int NUM_TERMS = 3;
	localparam int RELAY_TERM = 2;
	// Function codes and command source value
	localparam logic [7:0] FN_RUN = 8'h00;
	localparam logic [7:0] FN_ALARM = 8'h05;
	localparam logic [1:0] SRC_OPERATOR = 2'h2;
	// Reset values
	localparam logic [31:0] ROUTE_RESET = {8'h00, FN_ALARM, FN_RUN, FN_RUN};
	localparam logic [15:0] MAX_FREQ_RESET = 16'h1770;
	localparam logic [15:0] START_FREQ_RESET = 16'h0032;
	localparam logic [31:0] RAMP_RESET = 32'h0000_2710;
	// Contact filter time
	localparam int CLK_MHZ = 100;
	localparam int DEB_TIME_MS = 50;
	localparam int DEB_CYCLES = DEB_TIME_MS * CLK_MHZ * 1000;
	// Run mode states, Gray along stop, run, stopping
	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_RUN = 2'b01,
		ST_STOPPING = 2'b11
	} rspr_state_e;
endpackage

/* File: rspr_contact_if.sv */
// Filtered contact levels passed from the filter to the block core
`timescale 1ns/10ps
interface rspr_contact_if;
	logic raise;
	logic lower;
	modport filt (output raise, output lower);
	modport user (input raise, input lower);
endinterface

/* File: rspr_debounce.sv */
// Two-flop synchroniser and hold-time filter for raise and lower contacts
`timescale 1ns/10ps
module rspr_debounce #(
	parameter int DEB_CYCLES = rspr_pkg::DEB_CYCLES
) (
	input wire logic clk_in, // System clock
	input wire logic rstn_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic [1:0] raw_in, // Raw contacts, bit0 raise, bit1 lower
	rspr_contact_if.filt contact // Filtered levels
);
	localparam int CW = $clog2(DEB_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(DEB_CYCLES - 1);
	logic [1:0] clean;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic meta;
			logic sync;
			logic [CW-1:0] cnt;
			wire differs = sync != clean[g];
			wire held = cnt == LAST;
			// Synchronise, then accept a new level only after it stays put
			always_ff @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					meta <= 1'b0;
					sync <= 1'b0;
					cnt <= '0;
					clean[g] <= 1'b0;
				end else if (ce_in) begin
					meta <= raw_in[g];
					sync <= meta;
					if (!differs) begin
						cnt <= '0;
					end else if (held) begin
						cnt <= '0;
						clean[g] <= sync;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
			end
		end
	endgenerate

	// Hand filtered levels to the core
	assign contact.raise = clean[0];
	assign contact.lower = clean[1];
endmodule

/* File: rspr_top.sv */
// Remote raise/lower speed setpoint, output frequency ramp and run output
// Functional notes
// - Raise input held: output frequency climbs from its present value.
// - On release of raise or lower the frequency holds where it is.
// - Lower input held: output frequency falls from its present value.
// - Steps use first accel/decel times, or second set when selected.
// - Raise and lower act only when command source equals 02.
// - Raise and lower are ignored while jog function is active.
// - Adjusted frequency stays between zero and the maximum setting.
// - Adjustment starts from the present output frequency and rewrites the standard frequency setting.
// - Run output active in run mode, inactive in stop mode.
// - Run output is active low, pulling the terminal to ground.
// - Run output asserts only above the start frequency.
// - Any output function may be routed to any of three terminals.
// - Relay carries alarm after reset and accepts any function.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module rspr_top #(
	parameter int FW = 16,
	parameter int DEB_CYCLES = rspr_pkg::DEB_CYCLES
) (
	input wire logic clk_in, // System clock, 100 MHz
	input wire logic rstn_in, // Async reset, active low
	input wire logic ce_in, // Clock enable, freezes all state
	input wire logic [5:0] address_in, // Avalon byte address
	input wire logic read_in, // Avalon read
	input wire logic write_in, // Avalon write
	input wire logic [31:0] writedata_in, // Avalon write data
	output logic [31:0] readdata_out, // Avalon read data
	output logic waitrequest_out, // Avalon wait request
	input wire logic raise_in, // Raise contact, async pin
	input wire logic speed_lower_input_in, // Lower contact, async pin
	input wire logic alarm_in, // Alarm state from trip logic
	output logic [1:0] oc_o_out, // Open-collector pin level
	output logic [1:0] oc_oe_out, // Open-collector enable, high sinks
	output logic relay_out, // Relay coil energised
	output logic [FW-1:0] out_freq_out // Present output frequency
);
	rspr_contact_if contact ();
	rspr_pkg::rspr_state_e state;
	rspr_pkg::rspr_state_e next_state;
	logic [2:0] ctrl;
	logic [1:0] src;
	logic [FW-1:0] std_freq;
	logic [FW-1:0] max_freq;
	logic [FW-1:0] start_freq;
	logic [31:0] first_accel_time;
	logic [31:0] first_decel_time;
	logic [31:0] second_set_accel_time;
	logic [31:0] second_set_decel_time;
	logic [31:0] route;
	logic [FW-1:0] out_freq;
	logic [31:0] step_cnt;
	logic ack;
	logic [31:0] readdata;

	// Contact synchroniser and filter
	rspr_debounce #(
		.DEB_CYCLES(DEB_CYCLES)
	) u_deb (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.raw_in({speed_lower_input_in, raise_in}),
		.contact(contact)
	);

	// Bus handshake: one wait state per access
	wire req = read_in | write_in;
	wire wr_take = write_in & ack;
	assign waitrequest_out = req & ~ack;
	assign readdata_out = readdata;

	// Address decode
	wire sel_ctrl = address_in == rspr_pkg::OFS_CTRL;
	wire sel_src = address_in == rspr_pkg::OFS_SRC;
	wire sel_std = address_in == rspr_pkg::OFS_STD_FREQ;
	wire sel_max = address_in == rspr_pkg::OFS_MAX_FREQ;
	wire sel_start = address_in == rspr_pkg::OFS_START_FREQ;
	wire sel_first_accel_time = address_in == rspr_pkg::OFS_FIRST_ACCEL_TIME;
	wire sel_first_decel_time = address_in == rspr_pkg::OFS_FIRST_DECEL_TIME;
	wire sel_acc2 = address_in == rspr_pkg::OFS_ACC2;
	wire sel_dec2 = address_in == rspr_pkg::OFS_DEC2;
	wire sel_route = address_in == rspr_pkg::OFS_ROUTE;
	wire sel_stat = address_in == rspr_pkg::OFS_STATUS;
	wire sel_outf = address_in == rspr_pkg::OFS_OUT_FREQ;

	// Control fields
	wire run_cmd = ctrl[rspr_pkg::CTRL_RUN_BIT];
	wire jog_function = ctrl[rspr_pkg::CTRL_JOG_BIT];
	wire use_set2 = ctrl[rspr_pkg::CTRL_SET2_BIT];

	// Run status: run mode and above start frequency
	wire run_mode = state != rspr_pkg::ST_STOP;
	wire run_active = run_mode & (out_freq > start_freq);

	// Status word
	wire [31:0] status_word = {
		26'h000_0000,
		state,
		1'b0,
		contact.lower,
		contact.raise,
		run_active
	};

	// Read data selection, unmapped reads return zero
	wire [31:0] rd_mux =
		sel_ctrl ? {29'h0000_0000, ctrl} :
		sel_src ? {30'h0000_0000, src} :
		sel_std ? 32'(std_freq) :
		sel_max ? 32'(max_freq) :
		sel_start ? 32'(start_freq) :
		sel_first_accel_time ? first_accel_time :
		sel_first_decel_time ? first_decel_time :
		sel_acc2 ? second_set_accel_time :
		sel_dec2 ? second_set_decel_time :
		sel_route ? route :
		sel_stat ? status_word :
		sel_outf ? 32'(out_freq) :
		32'h0000_0000;

	// Raise/lower enables, both together hold
	wire updn_ok = (state == rspr_pkg::ST_RUN) & (src == rspr_pkg::SRC_OPERATOR)
		& ~jog_function;
	wire do_raise = updn_ok & contact.raise & ~contact.lower;
	wire do_lower = updn_ok & contact.lower & ~contact.raise;

	// Ramp target, clamped to the maximum setting
	wire [FW-1:0] std_clamped = (std_freq > max_freq) ? max_freq : std_freq;
	wire [FW-1:0] target = (state == rspr_pkg::ST_RUN) ? std_clamped : '0;
	wire going_up = do_raise | (~do_lower & (out_freq < target));

	// Step interval from first or second time set
	wire [31:0] acc_time = use_set2 ? second_set_accel_time : first_accel_time;
	wire [31:0] dec_time = use_set2 ? second_set_decel_time : first_decel_time;
	wire [31:0] interval = going_up ? acc_time : dec_time;
	wire tick = (step_cnt + 32'h0000_0001) >= interval;

	// Next frequency from raise/lower, else from the normal ramp
	wire [FW-1:0] up_val = (out_freq >= max_freq) ? max_freq : out_freq + 1'b1;
	wire [FW-1:0] dn_val = (out_freq == '0) ? '0 : out_freq - 1'b1;
	wire [FW-1:0] ramp_val =
		(out_freq < target) ? out_freq + 1'b1 :
		(out_freq > target) ? out_freq - 1'b1 : out_freq;
	wire [FW-1:0] next_out = do_raise ? up_val : do_lower ? dn_val : ramp_val;
	wire moving = do_raise | do_lower | (out_freq != target);

	// Run mode sequence
	always_comb begin
		next_state = state;
		case (state)
			rspr_pkg::ST_STOP: begin
				if (run_cmd) begin
					next_state = rspr_pkg::ST_RUN;
				end
			end
			rspr_pkg::ST_RUN: begin
				if (!run_cmd) begin
					next_state = rspr_pkg::ST_STOPPING;
				end
			end
			rspr_pkg::ST_STOPPING: begin
				if (run_cmd) begin
					next_state = rspr_pkg::ST_RUN;
				end else if (out_freq == '0) begin
					next_state = rspr_pkg::ST_STOP;
				end
			end
			default: begin
				next_state = rspr_pkg::ST_STOP;
			end
		endcase
	end

	// Bus acknowledge and read data
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack <= 1'b0;
			readdata <= 32'h0000_0000;
		end else if (ce_in) begin
			ack <= req & ~ack;
			if (read_in & ~ack) begin
				readdata <= rd_mux;
			end
		end
	end

	// Configuration registers written by software
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl <= 3'h0;
			src <= 2'h0;
			max_freq <= rspr_pkg::MAX_FREQ_RESET[FW-1:0];
			start_freq <= rspr_pkg::START_FREQ_RESET[FW-1:0];
			first_accel_time <= rspr_pkg::RAMP_RESET;
			first_decel_time <= rspr_pkg::RAMP_RESET;
			second_set_accel_time <= rspr_pkg::RAMP_RESET;
			second_set_decel_time <= rspr_pkg::RAMP_RESET;
			route <= rspr_pkg::ROUTE_RESET;
		end else if (ce_in && wr_take) begin
			if (sel_ctrl) ctrl <= writedata_in[2:0];
			if (sel_src) src <= writedata_in[1:0];
			if (sel_max) max_freq <= writedata_in[FW-1:0];
			if (sel_start) start_freq <= writedata_in[FW-1:0];
			if (sel_first_accel_time) first_accel_time <= writedata_in;
			if (sel_first_decel_time) first_decel_time <= writedata_in;
			if (sel_acc2) second_set_accel_time <= writedata_in;
			if (sel_dec2) second_set_decel_time <= writedata_in;
			if (sel_route) route <= writedata_in;
		end
	end

	// Standard setting: software write wins, else raise/lower rewrites it
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			std_freq <= '0;
		end else if (ce_in) begin
			if (wr_take && sel_std) begin
				std_freq <= writedata_in[FW-1:0];
			end else if (tick && (do_raise || do_lower)) begin
				std_freq <= next_out;
			end
		end
	end

	// Output frequency ramp, step timer and state
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= rspr_pkg::ST_STOP;
			out_freq <= '0;
			step_cnt <= 32'h0000_0000;
		end else if (ce_in) begin
			state <= next_state;
			if (!moving || tick) begin
				step_cnt <= 32'h0000_0000;
			end else begin
				step_cnt <= step_cnt + 32'h0000_0001;
			end
			if (moving && tick) begin
				out_freq <= next_out;
			end
		end
	end

	assign out_freq_out = out_freq;

	// Terminal function selection, one per output
	logic [rspr_pkg::NUM_TERMS-1:0] term_act;
	genvar t;
	generate
		for (t = 0; t < rspr_pkg::NUM_TERMS; t++) begin : g_term
			wire [7:0] fn = route[t*rspr_pkg::ROUTE_FIELD_W +: rspr_pkg::ROUTE_FIELD_W];
			assign term_act[t] = (fn == rspr_pkg::FN_RUN) ? run_active :
				(fn == rspr_pkg::FN_ALARM) ? alarm_in : 1'b0;
		end
	endgenerate

	// Output registers; open collector sinks to ground when active
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			oc_oe_out <= 2'h0;
			relay_out <= 1'b0;
		end else if (ce_in) begin
			oc_oe_out <= term_act[1:0];
			relay_out <= term_act[rspr_pkg::RELAY_TERM];
		end
	end

	assign oc_o_out = 2'h0;
endmodule

/* File: rspr_switches.sv */
// Switch contact model driving the raise and lower pins
`timescale 1ns/10ps
module rspr_switches (
	input wire logic clk_in, // Clock
	input wire logic [1:0] press_in, // Wanted contacts
	output logic [1:0] raw_out // Pin levels
);
	logic [1:0] last = 2'b00;
	int n = 0;
	initial raw_out = 2'b00;
	// Contacts chatter for three cycles after each change
	always @(posedge clk_in) begin
		if (press_in != last) n <= 3;
		else if (n > 0) n <= n - 1;
		last <= press_in;
		raw_out <= (n > 0) ? ~raw_out : press_in;
	end
endmodule

/* File: rspr_top_props.sv */
// Port checks for the speed pot block
`timescale 1ns/10ps
module rspr_top_props #(
	parameter int FW = 16,
	parameter int DEB_CYCLES = 8
) (
	input wire logic clk_in, // Clock
	input wire logic rstn_in, // Reset
	input wire logic ce_in, // Enable
	input wire logic [5:0] address_in, // Address
	input wire logic read_in, // Read
	input wire logic write_in, // Write
	input wire logic [31:0] writedata_in, // Data in
	input wire logic [31:0] readdata_out, // Data out
	input wire logic waitrequest_out, // Wait
	input wire logic alarm_in, // Alarm
	input wire logic [1:0] oc_o_out, // Pin level
	input wire logic [1:0] oc_oe_out, // Pin sink
	input wire logic relay_out, // Relay
	input wire logic [FW-1:0] out_freq_out // Frequency
);
	logic [31:0] rt;
	logic [FW-1:0] mx;
	wire logic wr_ok = write_in && !waitrequest_out;
	// Shadow of routing and ceiling settings
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rt <= rspr_pkg::ROUTE_RESET;
			mx <= rspr_pkg::MAX_FREQ_RESET;
		end else if (wr_ok && address_in == rspr_pkg::OFS_ROUTE) begin
			rt <= writedata_in;
		end else if (wr_ok && address_in == rspr_pkg::OFS_MAX_FREQ) begin
			mx <= writedata_in[FW-1:0];
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Bus request phases
	sequence s_req_wait;
		(read_in || write_in) && waitrequest_out && ce_in;
	endsequence
	sequence s_req_done;
		(read_in || write_in) && !waitrequest_out;
	endsequence
	a_bus_one_wait: assert property (s_req_wait |=> !waitrequest_out)
		else $error("no answer after one wait");
	a_ack_once: assert property (s_req_done |=> waitrequest_out || !(read_in || write_in))
		else $error("answer held too long");
	a_unmapped_zero: assert property ((s_req_done and (read_in && address_in == 6'h30))
		|-> readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
	a_pin_low: assert property (oc_o_out == 2'b00)
		else $error("open collector drives high");
	a_freq_step: assert property (out_freq_out == $past(out_freq_out)
		|| out_freq_out == $past(out_freq_out) + 1'b1
		|| out_freq_out == $past(out_freq_out) - 1'b1) else $error("frequency jump");
	a_freq_ceiling: assert property (out_freq_out <= mx)
		else $error("frequency above maximum");
	a_run_start: assert property (oc_oe_out[0]
		|-> $past(out_freq_out) > rspr_pkg::START_FREQ_RESET) else $error("run early");
	a_relay_alarm: assert property ($past(rstn_in)
		&& $past(rt[23:16]) == rspr_pkg::FN_ALARM |-> relay_out == $past(alarm_in))
		else $error("relay not alarm");
	a_route_run: assert property ($past(rt[23:16]) == rspr_pkg::FN_RUN
		&& $past(rt[7:0]) == rspr_pkg::FN_RUN
		|-> relay_out == oc_oe_out[0]) else $error("relay not run");
	a_route_idle: assert property ($past(rt[23:16]) == 8'h07 |-> !relay_out)
		else $error("unused code active");
endmodule
bind rspr_top rspr_top_props #(.FW(FW), .DEB_CYCLES(DEB_CYCLES)) i_rspr_top_props (
	.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .address_in(address_in),
	.read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
	.readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .alarm_in(alarm_in),
	.oc_o_out(oc_o_out), .oc_oe_out(oc_oe_out), .relay_out(relay_out),
	.out_freq_out(out_freq_out)
);

/* File: tb_rspr_top.sv */
// Self-checking bench for the speed pot block
`timescale 1ns/10ps
module tb_rspr_top;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [5:0] address_in = 6'h00;
	logic read_in = 1'b0;
	logic write_in = 1'b0;
	logic [31:0] writedata_in = 32'h0000_0000;
	logic alarm_in = 1'b0;
	logic [1:0] press = 2'b00;
	logic [1:0] raw;
	logic [31:0] readdata_out;
	logic waitrequest_out;
	logic [1:0] oc_o_out;
	logic [1:0] oc_oe_out;
	logic relay_out;
	logic [15:0] out_freq_out;
	logic [31:0] seed = 32'hb501_8649;
	logic [31:0] q[$];
	int n_fail = 0;
	int tests_run = 0;
	rspr_top #(.FW(16), .DEB_CYCLES(8)) i_rspr_top (
		.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .address_in(address_in),
		.read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
		.readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
		.raise_in(raw[0]), .speed_lower_input_in(raw[1]), .alarm_in(alarm_in),
		.oc_o_out(oc_o_out), .oc_oe_out(oc_oe_out), .relay_out(relay_out),
		.out_freq_out(out_freq_out)
	);
	rspr_switches i_rspr_switches (.clk_in(clk_in), .press_in(press), .raw_out(raw));
	initial forever #5 clk_in = ~clk_in;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Random alarm level, quiet in reset
	always @(posedge clk_in) begin
		seed <= xs(seed);
		alarm_in <= rstn_in & seed[7];
	end
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// Read data checked against the oldest note
	always @(negedge clk_in) begin
		if (read_in && waitrequest_out === 1'b0) cmp(q.pop_front(), readdata_out);
	end
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_in);
		address_in <= a;
		writedata_in <= d;
		read_in <= !w;
		write_in <= w;
		@(negedge clk_in);
		for (i = 0; i < 50 && waitrequest_out !== 1'b0; i++) @(negedge clk_in);
		if (i == 50) begin
			n_fail++;
			finish_test();
		end
		@(posedge clk_in);
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	// Contacts held well past the filter time
	task automatic hold(input logic [1:0] p, input int n);
		@(posedge clk_in);
		press <= p;
		repeat (n) @(posedge clk_in);
		press <= 2'b00;
		repeat (30) @(posedge clk_in);
	endtask
	// Main sequence
	initial begin
		int i;
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd(rspr_pkg::OFS_ROUTE, rspr_pkg::ROUTE_RESET);
		rd(rspr_pkg::OFS_START_FREQ, {16'h0000, rspr_pkg::START_FREQ_RESET});
		rd(6'h30, 32'h0000_0000);
		wr(rspr_pkg::OFS_SRC, 32'h0000_0002);
		wr(rspr_pkg::OFS_STD_FREQ, 32'h0000_0040);
		wr(rspr_pkg::OFS_MAX_FREQ, 32'h0000_0048);
		wr(rspr_pkg::OFS_FIRST_ACCEL_TIME, 32'h0000_0002);
		wr(rspr_pkg::OFS_FIRST_DECEL_TIME, 32'h0000_0002);
		wr(rspr_pkg::OFS_CTRL, 32'h0000_0001);
		for (i = 0; i < 2000 && out_freq_out !== 16'h0040; i++) @(negedge clk_in);
		if (i == 2000) begin
			n_fail++;
			finish_test();
		end
		rd(rspr_pkg::OFS_STATUS, 32'h0000_0011);
		wr(rspr_pkg::OFS_ROUTE, 32'h0000_0000);
		rd(rspr_pkg::OFS_ROUTE, 32'h0000_0000);
		wr(rspr_pkg::OFS_CTRL, 32'h0000_0003);
		hold(2'b01, 40);
		rd(rspr_pkg::OFS_OUT_FREQ, 32'h0000_0040);
		wr(rspr_pkg::OFS_CTRL, 32'h0000_0001);
		wr(rspr_pkg::OFS_SRC, 32'h0000_0001);
		hold(2'b01, 40);
		rd(rspr_pkg::OFS_OUT_FREQ, 32'h0000_0040);
		wr(rspr_pkg::OFS_SRC, 32'h0000_0002);
		wr(rspr_pkg::OFS_ACC2, 32'h0000_03E8);
		wr(rspr_pkg::OFS_CTRL, 32'h0000_0005);
		hold(2'b01, 40);
		rd(rspr_pkg::OFS_OUT_FREQ, 32'h0000_0040);
		wr(rspr_pkg::OFS_CTRL, 32'h0000_0001);
		hold(2'b11, 40);
		rd(rspr_pkg::OFS_OUT_FREQ, 32'h0000_0040);
		wr(rspr_pkg::OFS_ROUTE, 32'h0007_0500);
		rd(rspr_pkg::OFS_ROUTE, 32'h0007_0500);
		hold(2'b01, 60);
		rd(rspr_pkg::OFS_OUT_FREQ, 32'h0000_0048);
		rd(rspr_pkg::OFS_STD_FREQ, 32'h0000_0048);
		hold(2'b10, 200);
		rd(rspr_pkg::OFS_OUT_FREQ, 32'h0000_0000);
		rd(rspr_pkg::OFS_STATUS, 32'h0000_0010);
		wr(rspr_pkg::OFS_CTRL, 32'h0000_0000);
		rd(rspr_pkg::OFS_CTRL, 32'h0000_0000);
		rd(rspr_pkg::OFS_STATUS, 32'h0000_0000);
		repeat (3) @(posedge clk_in);
		finish_test();
	end
endmodule
